// ---- hdl/eprd_detector.sv ----
// external pin request detector with register port and interrupt output
// Overview of operation
// - bit 6 set turns pull device off; clear means pull active when enabled
// - bit 5 picks polarity: 0 falling/low, 1 rising/high
// - rising polarity with pull active pulls pin down, else up
// - bit 4 enables pin as request input; otherwise no detection
// - bit 3 read-only event flag set by detected events
// - bit 2 write one clears flag; write zero nothing; reads zero
// - level mode keeps flag set while pin stays asserted
// - bit 1 forwards flag as processor request, else polling only
// - bit 0 selects edge-only or edge plus level detection
// - enabled pin reaches wake logic on an unclocked path in stop
`timescale 1ns/1ps
`default_nettype none
module eprd_detector (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       pin_in,
  output logic            pull_up_en,
  output logic            pull_down_en,
  output logic            cpu_request,
  output logic            irq_out,
  output logic            wake_request
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic       pull_device_disable, next_pull_device_disable;
  logic       polarity_select, next_polarity_select;
  logic       pin_function_enable, next_pin_function_enable;
  logic       request_event_flag, next_request_event_flag;
  logic       request_interrupt_enable, next_request_interrupt_enable;
  logic       detection_mode_select, next_detection_mode_select;
  logic       sync_first, sync_second, pin_prev;
  logic       next_pin_prev;
  logic [7:0] irq_status, next_irq_status;
  logic [7:0] irq_mask, next_irq_mask;
  logic [7:0] next_reg_rdata;
  logic       next_pull_up_en, next_pull_down_en, next_cpu_request, next_irq_out;
  logic       asserted_now, edge_seen, level_hold, event_now, ack_write;
  logic       ctrl_write;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  // first stage is read only by the second stage
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync_first  <= 1'b0;
      sync_second <= 1'b0;
    end else begin
      sync_first  <= pin_in;
      sync_second <= sync_first;
    end
  end

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  // polarity folded in so asserted means active level in either sense
  always_comb begin
    asserted_now = polarity_select ? sync_second : ~sync_second;
    next_pin_prev = asserted_now;
    edge_seen  = pin_function_enable & asserted_now & ~pin_prev;
    level_hold = pin_function_enable & detection_mode_select
                 & asserted_now;
    event_now  = edge_seen | level_hold;
    ctrl_write = reg_wr & (reg_addr == eprd_pkg::ADDR_STATUS_CONTROL);
    ack_write  = ctrl_write & reg_wdata[eprd_pkg::BIT_ACK];
  end

  // ----------------------------------------------------------------
  // registers and flag
  // ----------------------------------------------------------------
  // the event flag ignores written data; only detection and ack touch it
  always_comb begin
    next_pull_device_disable      = pull_device_disable;
    next_polarity_select          = polarity_select;
    next_pin_function_enable      = pin_function_enable;
    next_request_interrupt_enable = request_interrupt_enable;
    next_detection_mode_select    = detection_mode_select;
    next_irq_mask                 = irq_mask;
    next_irq_status               = irq_status;
    if (ctrl_write) begin
      next_pull_device_disable      = reg_wdata[eprd_pkg::BIT_PULL_DISABLE];
      next_polarity_select          = reg_wdata[eprd_pkg::BIT_POLARITY];
      next_pin_function_enable      = reg_wdata[eprd_pkg::BIT_PIN_ENABLE];
      next_request_interrupt_enable = reg_wdata[eprd_pkg::BIT_IRQ_ENABLE];
      next_detection_mode_select    = reg_wdata[eprd_pkg::BIT_MODE];
    end
    if (reg_wr && reg_addr == eprd_pkg::ADDR_IRQ_MASK) begin
      next_irq_mask = reg_wdata;
    end
    // set wins over clear in the same cycle
    next_request_event_flag = request_event_flag;
    if (ack_write) begin
      next_request_event_flag = 1'b0;
    end
    if (event_now) begin
      next_request_event_flag = 1'b1;
    end
    // status clears on read, a coincident event still lands
    if (reg_rd && reg_addr == eprd_pkg::ADDR_IRQ_STATUS) begin
      next_irq_status = 8'h00;
    end
    if (event_now) begin
      next_irq_status[eprd_pkg::EVT_PIN_EVENT] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read mux and outputs
  // ----------------------------------------------------------------
  // ack bit and bit 7 read zero; unmapped addresses read zero
  always_comb begin
    next_reg_rdata = eprd_pkg::READ_ZERO;
    if (reg_rd) begin
      unique case (reg_addr)
        eprd_pkg::ADDR_STATUS_CONTROL: begin
          next_reg_rdata[eprd_pkg::BIT_PULL_DISABLE] = pull_device_disable;
          next_reg_rdata[eprd_pkg::BIT_POLARITY]     = polarity_select;
          next_reg_rdata[eprd_pkg::BIT_PIN_ENABLE]   = pin_function_enable;
          next_reg_rdata[eprd_pkg::BIT_EVENT_FLAG]   = request_event_flag;
          next_reg_rdata[eprd_pkg::BIT_IRQ_ENABLE]   = request_interrupt_enable;
          next_reg_rdata[eprd_pkg::BIT_MODE]         = detection_mode_select;
        end
        eprd_pkg::ADDR_IRQ_STATUS: next_reg_rdata = irq_status;
        eprd_pkg::ADDR_IRQ_MASK:   next_reg_rdata = irq_mask;
        default:                   next_reg_rdata = eprd_pkg::READ_ZERO;
      endcase
    end
    // pull choice follows new settings on the same edge that loads the control register
    next_pull_up_en   = next_pin_function_enable & ~next_pull_device_disable
                        & ~next_polarity_select;
    next_pull_down_en = next_pin_function_enable & ~next_pull_device_disable
                        & next_polarity_select;
    next_cpu_request  = next_request_interrupt_enable & next_request_event_flag;
    next_irq_out      = |(next_irq_status & next_irq_mask);
  end

  // ----------------------------------------------------------------
  // register stage
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pull_device_disable      <= eprd_pkg::RESET_CONTROL[eprd_pkg::BIT_PULL_DISABLE];
      polarity_select          <= eprd_pkg::RESET_CONTROL[eprd_pkg::BIT_POLARITY];
      pin_function_enable      <= eprd_pkg::RESET_CONTROL[eprd_pkg::BIT_PIN_ENABLE];
      request_event_flag       <= eprd_pkg::RESET_CONTROL[eprd_pkg::BIT_EVENT_FLAG];
      request_interrupt_enable <= eprd_pkg::RESET_CONTROL[eprd_pkg::BIT_IRQ_ENABLE];
      detection_mode_select    <= eprd_pkg::RESET_CONTROL[eprd_pkg::BIT_MODE];
      irq_status               <= eprd_pkg::READ_ZERO;
      irq_mask                 <= eprd_pkg::RESET_MASK;
      pin_prev                 <= 1'b1;  // blocks a false edge right after reset
      reg_rdata                <= eprd_pkg::READ_ZERO;
      pull_up_en               <= 1'b0;
      pull_down_en             <= 1'b0;
      cpu_request              <= 1'b0;
      irq_out                  <= 1'b0;
    end else begin
      pull_device_disable      <= next_pull_device_disable;
      polarity_select          <= next_polarity_select;
      pin_function_enable      <= next_pin_function_enable;
      request_event_flag       <= next_request_event_flag;
      request_interrupt_enable <= next_request_interrupt_enable;
      detection_mode_select    <= next_detection_mode_select;
      irq_status               <= next_irq_status;
      irq_mask                 <= next_irq_mask;
      pin_prev                 <= next_pin_prev;
      reg_rdata                <= next_reg_rdata;
      pull_up_en               <= next_pull_up_en;
      pull_down_en             <= next_pull_down_en;
      cpu_request              <= next_cpu_request;
      irq_out                  <= next_irq_out;
    end
  end

  // ----------------------------------------------------------------
  // stop-mode wake path
  // ----------------------------------------------------------------
  // registered enable and polarity gate the raw pin; no clock edge needed
  // once clocks stop, so wake works with the detector frozen
  // limitation: this output is combinational from pin_in by design
  assign wake_request = pin_function_enable & (pin_in ~^ polarity_select);
endmodule : eprd_detector
`default_nettype wire

// ---- hdl/eprd_pkg.sv ----
// package of constants for the external pin request detector
package eprd_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_IRQ_STATUS     = 4'h1;
  localparam logic [3:0] ADDR_IRQ_MASK       = 4'h2;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // ----------------------------------------------------------------
  // field positions of the status/control register
  // ----------------------------------------------------------------
  localparam int BIT_PULL_DISABLE = 6;
  localparam int BIT_POLARITY     = 5;
  localparam int BIT_PIN_ENABLE   = 4;
  localparam int BIT_EVENT_FLAG   = 3;
  localparam int BIT_ACK          = 2;
  localparam int BIT_IRQ_ENABLE   = 1;
  localparam int BIT_MODE         = 0;
  // ----------------------------------------------------------------
  // status and mask layout, reset values
  // ----------------------------------------------------------------
  localparam int EVT_PIN_EVENT = 0;
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_MASK    = 8'h00;
  localparam logic [7:0] READ_ZERO     = 8'h00;
endpackage : eprd_pkg

// ---- dv/eprd_pin_model.sv ----
// model of the external device that drives the request pin
`timescale 1ns/1ps
`default_nettype none
module eprd_pin_model (
  input  wire logic mclk,
  input  wire logic drive_en,
  input  wire logic drive_val,
  input  wire logic pull_up_en,
  input  wire logic pull_down_en,
  output logic      pin
);
  logic toggle = 1'b0;
  // changing pattern so a floating pin never settles to a friendly value
  always_ff @(posedge mclk) toggle <= ~toggle;
  // a released pin shows the pull level, or floats when no pull is on
  always_comb begin
    if (drive_en) pin = drive_val;
    else if (pull_up_en) pin = 1'b1;
    else if (pull_down_en) pin = 1'b0;
    else pin = toggle;
  end
endmodule : eprd_pin_model
`default_nettype wire

// ---- dv/eprd_detector_assertions.sv ----
// checker module and bind for the external pin request detector
`timescale 1ns/1ps
`default_nettype none
module eprd_detector_chk (
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       pin_in,
  input wire logic       pull_up_en,
  input wire logic       pull_down_en,
  input wire logic       cpu_request,
  input wire logic       irq_out,
  input wire logic       wake_request
);
  logic [7:0] ctl, next_ctl;
  // shadow of the control register, rebuilt from bus writes
  always_comb next_ctl = (reg_wr && reg_addr == 4'h0) ? reg_wdata : ctl;
  always_ff @(posedge mclk) ctl <= sys_rst ? 8'h00 : next_ctl;
  wire logic armed = ctl[4] && ctl[1];
  wire logic asrt  = pin_in == ctl[5];
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // request steps: quiet pin, then asserted level through the sync
  // ----------------------------------------------------------------
  sequence edge_seen; (armed && !asrt)[*3] ##1 (armed && asrt)[*4]; endsequence
  sequence level_held; (armed && ctl[0] && asrt)[*5]; endsequence
  chk_pull_up_map: assert property (pull_up_en == (ctl[4] && !ctl[6] && !ctl[5]))
    else $error("pull-up enable does not match control");
  chk_pull_dn_map: assert property (pull_down_en == (ctl[4] && !ctl[6] && ctl[5]))
    else $error("pull-down enable does not match control");
  chk_wake_path: assert property (wake_request == (ctl[4] && asrt))
    else $error("wake request does not follow the pin");
  chk_req_gate: assert property (cpu_request |-> ctl[1])
    else $error("request raised while disabled");
  chk_ctl_readback: assert property (reg_rd && reg_addr == 4'h0 |=>
    (reg_rdata & 8'hF7) == (ctl & 8'h73)) else $error("control read back wrong");
  chk_unmapped_zero: assert property (reg_rd && reg_addr > 4'h2 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_read_one_cyc: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  chk_edge_walk: assert property (edge_seen |=> cpu_request)
    else $error("edge not turned into a request in time");
  chk_level_hold: assert property (level_held |=> cpu_request)
    else $error("held level did not keep the request");
endmodule : eprd_detector_chk
bind eprd_detector eprd_detector_chk i_chk (.mclk(mclk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pin_in(pin_in), .pull_up_en(pull_up_en),
  .pull_down_en(pull_down_en), .cpu_request(cpu_request), .irq_out(irq_out),
  .wake_request(wake_request));
`default_nettype wire

// ---- dv/test_external_pin_request_detector.sv ----
// self-checking bench for the external pin request detector
`timescale 1ns/1ps
`default_nettype none
module test_external_pin_request_detector;
  logic        mclk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, v;
  logic        drive_en = 1'b1, drive_val = 1'b1, pin, pull_up_en, pull_down_en;
  logic        cpu_request, irq_out, wake_request;
  int          error_cnt = 0, check_count = 0, cycles = 0;
  // rows: control, pin level, expected {pull-up, pull-down, wake}
  logic [11:0] rows [8] = '{12'h10C, 12'h105, 12'h30B, 12'h501, 12'h700, 12'h000,
                            12'h208, 12'h372};
  // 100 MHz clock
  always #5 mclk = ~mclk;
  eprd_detector i_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_in(pin), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
    .cpu_request(cpu_request), .irq_out(irq_out), .wake_request(wake_request));
  eprd_pin_model i_pin (.mclk(mclk), .drive_en(drive_en), .drive_val(drive_val),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .pin(pin));
  // ----------------------------------------------------------------
  // bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  // hang guard: a run of about 150 cycles never gets near this
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // main sequence: reset, table of configurations, then request cases
  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    tick(1);
    chk("outputs", 8'h00, {3'h0, pull_up_en, pull_down_en, cpu_request, irq_out, wake_request});
    rd(eprd_pkg::ADDR_STATUS_CONTROL, v);
    chk("control", eprd_pkg::RESET_CONTROL, v);
    rd(eprd_pkg::ADDR_IRQ_MASK, v);
    chk("mask", eprd_pkg::RESET_MASK, v);
    rd(4'hF, v);
    chk("unmapped", eprd_pkg::READ_ZERO, v);
    foreach (rows[i]) begin
      wr(eprd_pkg::ADDR_STATUS_CONTROL, rows[i][11:4]);
      drive_val <= rows[i][3];
      tick(3);
      chk("pins", {5'h00, rows[i][2:0]}, {5'h00, pull_up_en, pull_down_en, wake_request});
      rd(eprd_pkg::ADDR_STATUS_CONTROL, v);
      chk("readback", rows[i][11:4] & 8'h73, v & 8'hF7);
    end
    // falling edge, edge-only mode, exact latency of the request
    drive_val <= 1'b1;
    wr(eprd_pkg::ADDR_IRQ_MASK, 8'h01);
    wr(eprd_pkg::ADDR_STATUS_CONTROL, 8'h16);
    tick(4);
    wr(eprd_pkg::ADDR_STATUS_CONTROL, 8'h16);
    rd(eprd_pkg::ADDR_IRQ_STATUS, v);
    @(posedge mclk);
    drive_val <= 1'b0;
    // flag and request register on the same edge, one edge after the sync output
    tick(2);
    chk("early", 8'h00, {7'h00, cpu_request});
    tick(1);
    chk("request", 8'h03, {6'h00, cpu_request, irq_out});
    rd(eprd_pkg::ADDR_STATUS_CONTROL, v);
    chk("flag", 8'h1A, v);
    rd(eprd_pkg::ADDR_IRQ_STATUS, v);
    chk("status", 8'h01, v);
    rd(eprd_pkg::ADDR_IRQ_STATUS, v);
    chk("cleared", 8'h00, v);
    tick(1);
    chk("irq drop", 8'h02, {6'h00, cpu_request, irq_out});
    wr(eprd_pkg::ADDR_STATUS_CONTROL, 8'h1A);
    rd(eprd_pkg::ADDR_STATUS_CONTROL, v);
    chk("ack zero", 8'h1A, v);
    wr(eprd_pkg::ADDR_STATUS_CONTROL, 8'h16);
    rd(eprd_pkg::ADDR_STATUS_CONTROL, v);
    chk("ack one", 8'h12, v);
    drive_val <= 1'b1;
    tick(6);
    chk("rise ignored", 8'h00, {7'h00, cpu_request});
    // rising polarity, level mode, mask off: ack refused while held
    wr(eprd_pkg::ADDR_IRQ_MASK, 8'h00);
    drive_val <= 1'b0;
    wr(eprd_pkg::ADDR_STATUS_CONTROL, 8'h37);
    tick(4);
    drive_val <= 1'b1;
    tick(6);
    chk("level", 8'h02, {6'h00, cpu_request, irq_out});
    wr(eprd_pkg::ADDR_STATUS_CONTROL, 8'h37);
    rd(eprd_pkg::ADDR_STATUS_CONTROL, v);
    chk("held", 8'h3B, v);
    drive_val <= 1'b0;
    tick(4);
    wr(eprd_pkg::ADDR_STATUS_CONTROL, 8'h37);
    rd(eprd_pkg::ADDR_STATUS_CONTROL, v);
    chk("released", 8'h33, v);
    // reset again in mid-run: outputs and control must return to reset state
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    tick(1);
    chk("rst outputs", 8'h00, {3'h0, pull_up_en, pull_down_en, cpu_request, irq_out, wake_request});
    rd(eprd_pkg::ADDR_STATUS_CONTROL, v);
    chk("rst control", eprd_pkg::RESET_CONTROL, v);
    give_verdict();
  end
endmodule : test_external_pin_request_detector
`default_nettype wire
